// ===== src/pmmi_consts.vh
// Shared constants of the pluggable module management block
`ifndef PMMI_CONSTS_VH
`define PMMI_CONSTS_VH
`define PMMI_DEV_ADDR   7'h50
`define PMMI_TSEL_LOC   8'h7F
`define PMMI_STAT_LOC   8'h6E
`define PMMI_PTR_RST    8'h00
`define PMMI_BYTE_BITS  4'h8
`define PMMI_MEM_AW     10
`define PMMI_MEM_DEPTH  640
`define PMMI_PAGE_LOW   3'h0
`define PMMI_PAGE_STEP  3'h1
`define PMMI_NSYNC      5
`define PMMI_SYNC_RST   5'h07
`define PMMI_S_SCL      0
`define PMMI_S_SDA      1
`define PMMI_S_SEL      2
`define PMMI_S_LOFF     3
`define PMMI_S_PD       4
`define PMMI_AXI_AW     8
`define PMMI_OFF_CTRL   8'h00
`define PMMI_OFF_STATUS 8'h04
`define PMMI_OFF_INT    8'h08
`define PMMI_OFF_MASK   8'h0C
`define PMMI_OFF_MADDR  8'h10
`define PMMI_OFF_MDATA  8'h14
`define PMMI_RESP_OK    2'h0
`define PMMI_RESP_ERR   2'h2
`define PMMI_CTRL_LOST  0
`define PMMI_CTRL_FAULT 1
`define PMMI_CTRL_ALARM 2
`define PMMI_CTRL_W     3
`define PMMI_IRQ_WR     0
`define PMMI_IRQ_TSEL   1
`define PMMI_IRQ_RST    2
`define PMMI_IRQ_LOFF   3
`define PMMI_IRQ_W      4
`define PMMI_TSEL_MSB   1
`endif

// ===== src/pmmi_mem.v
// Byte memory of the management map with registered read data
`timescale 1ns/1ps
`include "pmmi_consts.vh"
module pmmi_mem (
  input  wire                    clock_i, // System clock
  input  wire                    rst_i,   // Async reset, active high
  input  wire                    ce_i,    // Clock enable
  input  wire                    we_i,    // Write strobe
  input  wire [`PMMI_MEM_AW-1:0] addr_i,  // Byte address
  input  wire [7:0]              wdata_i, // Write byte
  output reg  [7:0]              rdata_o  // Byte at last cycle's address
);
  reg [7:0] mem [0:`PMMI_MEM_DEPTH-1];
  always @(posedge clock_i)
  begin
    if (ce_i && we_i)
      mem[addr_i] <= wdata_i;
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (ce_i)
      rdata_o <= mem[addr_i];
  end
endmodule

// ===== src/pmmi_sync.v
// Two-flop synchronisers for the pins, one per bit
`timescale 1ns/1ps
`include "pmmi_consts.vh"
module pmmi_sync (
  input  wire                     clock_i, // System clock
  input  wire                     rst_i,   // Async reset, active high
  input  wire                     ce_i,    // Clock enable
  input  wire [`PMMI_NSYNC-1:0]   raw_i,   // Raw pin levels
  output wire [`PMMI_NSYNC-1:0]   sync_o   // Synchronised levels
);
  reg [`PMMI_NSYNC-1:0] stage1;
  reg [`PMMI_NSYNC-1:0] stage2;
  localparam [`PMMI_NSYNC-1:0] RST_VAL = `PMMI_SYNC_RST;
  genvar g;
  generate
    for (g = 0; g < `PMMI_NSYNC; g = g + 1)
    begin : g_bit
      always @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          stage1[g] <= RST_VAL[g];
          stage2[g] <= RST_VAL[g];
        end
        else if (ce_i)
        begin
          stage1[g] <= raw_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate
  assign sync_o = stage2;
endmodule

// ===== src/pmmi_top.v
// Management logic of a pluggable module: 2-wire slave, paged map, sideband pins
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pmmi_consts.vh"
module pmmi_top (
  input  wire                   clock_i,                  // System clock, 10 MHz
  input  wire                   rst_i,                    // Async reset, active high
  input  wire                   ce_i,                     // Clock enable
  input  wire [`PMMI_AXI_AW-1:0] s_axi_awaddr_i,          // Write address
  input  wire                   s_axi_awvalid_i,          // Write address valid
  output wire                   s_axi_awready_o,          // Write address ready
  input  wire [31:0]            s_axi_wdata_i,            // Write data
  input  wire [3:0]             s_axi_wstrb_i,            // Write byte strobes
  input  wire                   s_axi_wvalid_i,           // Write data valid
  output wire                   s_axi_wready_o,           // Write data ready
  output reg  [1:0]             s_axi_bresp_o,            // Write response
  output reg                    s_axi_bvalid_o,           // Write response valid
  input  wire                   s_axi_bready_i,           // Write response ready
  input  wire [`PMMI_AXI_AW-1:0] s_axi_araddr_i,          // Read address
  input  wire                   s_axi_arvalid_i,          // Read address valid
  output wire                   s_axi_arready_o,          // Read address ready
  output reg  [31:0]            s_axi_rdata_o,            // Read data
  output reg  [1:0]             s_axi_rresp_o,            // Read response
  output reg                    s_axi_rvalid_o,           // Read data valid
  input  wire                   s_axi_rready_i,           // Read data ready
  output reg                    irq_o,                    // Interrupt to local CPU
  input  wire                   module_select_n_i,        // Select pin, active low
  input  wire                   scl_i,                    // 2-wire clock pin
  input  wire                   sda_i,                    // 2-wire data pin level
  output wire                   sda_o,                    // 2-wire data drive value
  output reg                    sda_oe_o,                 // 2-wire data drive enable
  input  wire                   laser_off_request_i,      // Laser-off pin
  input  wire                   power_down_reset_i,       // Power-down/reset pin
  output reg                    interrupt_n_o,            // Interrupt pin, active low
  output reg                    receive_signal_lost_oe_o, // Pulls signal-lost pin low
  output reg                    fault_not_ready_oe_o,     // Pulls not-ready pin low
  output wire                   presence_indicator_o,     // Presence pin
  output reg                    laser_enable_o,           // Laser driver enable
  output reg                    low_power_o               // Low-power state request
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_ACK   = 3'h2;
  localparam [2:0] ST_WOFF  = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;

  wire [`PMMI_NSYNC-1:0] pin_s;
  reg                    scl_q;
  reg                    sda_q;
  reg                    pd_q;
  reg                    loff_q;
  reg  [2:0]             state;
  reg  [2:0]             ack_to;
  reg  [3:0]             bitcnt;
  reg  [7:0]             shreg;
  reg  [7:0]             ptr;
  reg  [7:0]             tsel;
  reg                    i2c_we;
  reg                    tsel_wr;
  reg  [7:0]             i2c_wbyte;
  reg  [`PMMI_MEM_AW-1:0] i2c_waddr;
  reg  [7:0]             i2c_rd;
  reg                    own_q;
  reg  [`PMMI_CTRL_W-1:0] ctrl;
  reg  [`PMMI_IRQ_W-1:0] int_stat;
  reg  [`PMMI_IRQ_W-1:0] int_mask;
  reg                    sw_pend;
  reg                    sw_we;
  reg                    sw_cap;
  reg  [`PMMI_MEM_AW-1:0] sw_addr;
  reg  [7:0]             sw_wd;
  reg  [7:0]             sw_rbuf;
  reg                    aw_hold;
  reg                    w_hold;
  reg  [`PMMI_AXI_AW-1:0] aw_addr;
  reg  [31:0]            w_data;
  reg  [3:0]             w_strb;
  reg  [31:0]            rd_mux;
  reg                    rd_err;
  wire [7:0]             mem_rdata;

  // Pins from the host pass two flops; the select flop resets to deselected
  pmmi_sync u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .raw_i   ({power_down_reset_i, laser_off_request_i, module_select_n_i, sda_i, scl_i}),
    .sync_o  (pin_s)
  );

  wire scl_s    = pin_s[`PMMI_S_SCL];
  wire sda_s    = pin_s[`PMMI_S_SDA];
  wire selected = ~pin_s[`PMMI_S_SEL];
  wire loff_s   = pin_s[`PMMI_S_LOFF];
  wire pd_s     = pin_s[`PMMI_S_PD];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start    = scl_s & scl_q & sda_q & ~sda_s;
  wire stop     = scl_s & scl_q & ~sda_q & sda_s;
  wire srst     = pd_q & ~pd_s;

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      pd_q   <= 1'b0;
      loff_q <= 1'b0;
    end
    else if (ce_i)
    begin
      scl_q  <= scl_s;
      sda_q  <= sda_s;
      pd_q   <= pd_s;
      loff_q <= loff_s;
    end
  end

  // Lower half maps to page 0, upper half to page (table bits 1:0)+1
  wire [2:0] page = ptr[7] ? ({1'b0, tsel[`PMMI_TSEL_MSB:0]} + `PMMI_PAGE_STEP)
                           : `PMMI_PAGE_LOW;
  wire [`PMMI_MEM_AW-1:0] phys = {page, ptr[6:0]};
  wire [7:0] stat_byte = {3'h0, ctrl[`PMMI_CTRL_ALARM], ctrl[`PMMI_CTRL_FAULT],
                          ctrl[`PMMI_CTRL_LOST], pd_s, loff_s};
  wire [7:0] rd_byte = (ptr == `PMMI_STAT_LOC) ? stat_byte :
                       (ptr == `PMMI_TSEL_LOC) ? tsel : i2c_rd;

  // 2-wire slave; the low-power level is not looked at here
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state     <= ST_IDLE;
      ack_to    <= ST_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= `PMMI_PTR_RST;
      tsel      <= 8'h00;
      i2c_we    <= 1'b0;
      tsel_wr   <= 1'b0;
      i2c_wbyte <= 8'h00;
      i2c_waddr <= {`PMMI_MEM_AW{1'b0}};
      sda_oe_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      i2c_we  <= 1'b0;
      tsel_wr <= 1'b0;
      if (srst || !selected)
      begin
        state    <= ST_IDLE;
        bitcnt   <= 4'h0;
        sda_oe_o <= 1'b0;
        if (srst)
        begin
          ptr  <= `PMMI_PTR_RST;
          tsel <= 8'h00;
        end
      end
      else if (start)
      begin
        state    <= ST_ADDR;
        bitcnt   <= 4'h0;
        sda_oe_o <= 1'b0;
      end
      else if (stop)
      begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          ST_ADDR, ST_WOFF, ST_WDATA:
          begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RACK:
          begin
            if (sda_s)
              state <= ST_IDLE;
          end
          default:
            state <= state;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
          begin
            if (bitcnt == `PMMI_BYTE_BITS)
            begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == `PMMI_DEV_ADDR)
              begin
                sda_oe_o <= 1'b1;
                ack_to   <= shreg[0] ? ST_RDATA : ST_WOFF;
                state    <= ST_ACK;
              end
              else
                state <= ST_IDLE;
            end
          end
          ST_WOFF:
          begin
            if (bitcnt == `PMMI_BYTE_BITS)
            begin
              bitcnt   <= 4'h0;
              ptr      <= shreg;
              sda_oe_o <= 1'b1;
              ack_to   <= ST_WDATA;
              state    <= ST_ACK;
            end
          end
          ST_WDATA:
          begin
            if (bitcnt == `PMMI_BYTE_BITS)
            begin
              bitcnt    <= 4'h0;
              i2c_we    <= 1'b1;
              i2c_wbyte <= shreg;
              i2c_waddr <= phys;
              ptr       <= ptr + 8'h01;
              sda_oe_o  <= 1'b1;
              ack_to    <= ST_WDATA;
              state     <= ST_ACK;
              if (ptr == `PMMI_TSEL_LOC)
              begin
                tsel    <= shreg;
                tsel_wr <= 1'b1;
              end
            end
          end
          ST_ACK, ST_RACK:
          begin
            state    <= ack_to;
            bitcnt   <= 4'h0;
            sda_oe_o <= 1'b0;
            if (ack_to == ST_RDATA)
            begin
              state    <= ST_RDATA;
              shreg    <= rd_byte;
              sda_oe_o <= ~rd_byte[7];
              bitcnt   <= 4'h1;
            end
          end
          ST_RDATA:
          begin
            if (bitcnt == `PMMI_BYTE_BITS)
            begin
              sda_oe_o <= 1'b0;
              ptr      <= ptr + 8'h01;
              state    <= ST_RACK;
            end
            else
            begin
              shreg    <= {shreg[6:0], 1'b0};
              sda_oe_o <= ~shreg[6];
              bitcnt   <= bitcnt + 4'h1;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Memory port: a 2-wire write first, then a software access, else the pointer
  wire sw_go = sw_pend & ~i2c_we;
  pmmi_mem u_mem (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .we_i    (i2c_we | (sw_go & sw_we)),
    .addr_i  (sw_go ? sw_addr : (i2c_we ? i2c_waddr : phys)),
    .wdata_i (sw_go ? sw_wd : i2c_wbyte),
    .rdata_o (mem_rdata)
  );

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      own_q  <= 1'b0;
      i2c_rd <= 8'h00;
    end
    else if (ce_i)
    begin
      own_q <= ~sw_go & ~i2c_we;
      if (own_q)
        i2c_rd <= mem_rdata;
    end
  end

  // AXI4-Lite slave
  wire        do_wr = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire        wr_int = do_wr && (aw_addr == `PMMI_OFF_INT);
  wire [`PMMI_IRQ_W-1:0] int_clr = wr_int ? (w_data[`PMMI_IRQ_W-1:0] &
                                   wmask[`PMMI_IRQ_W-1:0]) : {`PMMI_IRQ_W{1'b0}};
  wire [`PMMI_IRQ_W-1:0] events = {loff_s ^ loff_q, srst, tsel_wr, i2c_we};
  wire [`PMMI_IRQ_W-1:0] next_int = (int_stat & ~int_clr) | events;

  assign s_axi_awready_o = ~aw_hold & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_hold & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always @*
  begin
    rd_err = 1'b0;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr_i)
      `PMMI_OFF_CTRL:   rd_mux[`PMMI_CTRL_W-1:0] = ctrl;
      `PMMI_OFF_STATUS: rd_mux[15:0] = {tsel, 3'h0, selected, pd_s, loff_s,
                                        sw_pend | sw_cap, state != ST_IDLE};
      `PMMI_OFF_INT:    rd_mux[`PMMI_IRQ_W-1:0] = int_stat;
      `PMMI_OFF_MASK:   rd_mux[`PMMI_IRQ_W-1:0] = int_mask;
      `PMMI_OFF_MADDR:  rd_mux[`PMMI_MEM_AW-1:0] = sw_addr;
      `PMMI_OFF_MDATA:  rd_mux[7:0] = sw_rbuf;
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold        <= 1'b0;
      w_hold         <= 1'b0;
      aw_addr        <= {`PMMI_AXI_AW{1'b0}};
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `PMMI_RESP_OK;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `PMMI_RESP_OK;
      s_axi_rdata_o  <= 32'h0000_0000;
      ctrl           <= {`PMMI_CTRL_W{1'b0}};
      int_mask       <= {`PMMI_IRQ_W{1'b0}};
      sw_pend        <= 1'b0;
      sw_we          <= 1'b0;
      sw_cap         <= 1'b0;
      sw_addr        <= {`PMMI_MEM_AW{1'b0}};
      sw_wd          <= 8'h00;
      sw_rbuf        <= 8'h00;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      sw_cap <= sw_go & ~sw_we;
      if (sw_go)
        sw_pend <= 1'b0;
      if (sw_cap)
        sw_rbuf <= mem_rdata;
      if (do_wr)
      begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= `PMMI_RESP_OK;
        case (aw_addr)
          `PMMI_OFF_CTRL:
            ctrl <= (ctrl & ~wmask[`PMMI_CTRL_W-1:0]) |
                    (w_data[`PMMI_CTRL_W-1:0] & wmask[`PMMI_CTRL_W-1:0]);
          `PMMI_OFF_MASK:
            int_mask <= (int_mask & ~wmask[`PMMI_IRQ_W-1:0]) |
                        (w_data[`PMMI_IRQ_W-1:0] & wmask[`PMMI_IRQ_W-1:0]);
          `PMMI_OFF_MADDR:
          begin
            sw_addr <= (sw_addr & ~wmask[`PMMI_MEM_AW-1:0]) |
                       (w_data[`PMMI_MEM_AW-1:0] & wmask[`PMMI_MEM_AW-1:0]);
            sw_pend <= 1'b1;
            sw_we   <= 1'b0;
          end
          `PMMI_OFF_MDATA:
          begin
            if (w_strb[0])
            begin
              sw_wd   <= w_data[7:0];
              sw_pend <= 1'b1;
              sw_we   <= 1'b1;
            end
          end
          `PMMI_OFF_INT, `PMMI_OFF_STATUS:
            s_axi_bresp_o <= `PMMI_RESP_OK;
          default:
            s_axi_bresp_o <= `PMMI_RESP_ERR;
        endcase
      end
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_mux;
        s_axi_rresp_o  <= rd_err ? `PMMI_RESP_ERR : `PMMI_RESP_OK;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_stat <= {`PMMI_IRQ_W{1'b0}};
      irq_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      int_stat <= next_int;
      irq_o    <= |(next_int & int_mask);
    end
  end

  // Sideband pins
  assign sda_o                = 1'b0;
  assign presence_indicator_o = 1'b0;

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interrupt_n_o            <= 1'b1;
      receive_signal_lost_oe_o <= 1'b1;
      fault_not_ready_oe_o     <= 1'b1;
      laser_enable_o           <= 1'b0;
      low_power_o              <= 1'b0;
    end
    else if (ce_i)
    begin
      interrupt_n_o            <= ~ctrl[`PMMI_CTRL_ALARM];
      receive_signal_lost_oe_o <= ~ctrl[`PMMI_CTRL_LOST];
      fault_not_ready_oe_o     <= ~ctrl[`PMMI_CTRL_FAULT];
      laser_enable_o           <= ~loff_s;
      low_power_o              <= pd_s;
    end
  end
endmodule

// ===== verification/pmmi_host_model.sv
// Behavioural 2-wire bus master on the host board
`timescale 1ns/1ps
module pmmi_host_model (
  input  wire logic sda_i,  // Data line
  output logic      scl_o,  // Clock line
  output logic      pl_o,   // Pulls data low
  output logic      sel_n_o // Select pin
);
  localparam int Q = 200;
  initial
  begin
    scl_o = 1'b1;
    pl_o = 1'b0;
    sel_n_o = 1'b1; // Undriven select counts as high
  end
  task automatic st(input logic s);
    #37 sel_n_o = s; // Only the addressed module is selected
    #Q pl_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q pl_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask
  task automatic bt(input logic b, output logic r);
    #Q pl_o = !b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bt(d[i], q[i]);
    bt(a, r);
  endtask
  task automatic sp();
    #Q pl_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q pl_o = 1'b0;
    #Q;
  endtask
endmodule

// ===== verification/pmmi_top_sva.sv
// Checker of the pin behaviour of the management block
`timescale 1ns/1ps
module pmmi_chk (
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic ce_i, // Clock enable
  input wire logic s_axi_wvalid_i, // Write data valid
  input wire logic module_select_n_i, // Select
  input wire logic sda_oe_o, // Data drive
  input wire logic laser_off_request_i, // Laser off
  input wire logic laser_enable_o, // Laser on
  input wire logic power_down_reset_i, // Power down
  input wire logic low_power_o, // Low power
  input wire logic interrupt_n_o, // Alarm pin
  input wire logic receive_signal_lost_oe_o, // Lost pin
  input wire logic fault_not_ready_oe_o // Fault pin
);
  logic [2:0] wv;
  // Recent register writes, the only cause of a change at the alarm, lost and fault pins
  always @(posedge clock_i or posedge rst_i)
    if (rst_i)
      wv <= 3'h0;
    else
      wv <= {wv[1:0], s_axi_wvalid_i};
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  a_desel_quiet: assert property (module_select_n_i [*6] |-> !sda_oe_o)
    else $error("data driven while deselected");
  a_ack_selected: assert property ($rose(sda_oe_o) |-> !module_select_n_i)
    else $error("drive began while deselected");
  a_laser_off: assert property ($stable(laser_off_request_i) [*4]
    |-> laser_enable_o != laser_off_request_i) else $error("laser state wrong");
  a_low_power: assert property ($stable(power_down_reset_i) [*4]
    |-> low_power_o == power_down_reset_i) else $error("low power state wrong");
  a_soft_reset: assert property ($fell(power_down_reset_i) |-> ##[2:6] !sda_oe_o)
    else $error("drive kept over reset");
  a_alarm_pin: assert property ($changed(interrupt_n_o) |-> |wv)
    else $error("alarm pin moved alone");
  a_lost_pin: assert property ($changed(receive_signal_lost_oe_o) |-> |wv)
    else $error("lost pin moved alone");
  a_fault_pin: assert property ($changed(fault_not_ready_oe_o) |-> |wv)
    else $error("fault pin moved alone");
endmodule
bind pmmi_top pmmi_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .module_select_n_i(module_select_n_i),
  .sda_oe_o(sda_oe_o), .laser_off_request_i(laser_off_request_i),
  .laser_enable_o(laser_enable_o), .power_down_reset_i(power_down_reset_i),
  .low_power_o(low_power_o), .interrupt_n_o(interrupt_n_o),
  .receive_signal_lost_oe_o(receive_signal_lost_oe_o),
  .fault_not_ready_oe_o(fault_not_ready_oe_o));

// ===== verification/tb_top.sv
// Self-checking bench of the management block
`timescale 1ns/1ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, lo = 1'b0, pd = 1'b0, k;
  logic        ce = 1'b1, bre = 1'b0, rre = 1'b0;
  logic [3:0]  sb = 4'hF;
  logic [7:0]  aa = 8'h00, ts = 8'h00, q;
  logic [31:0] wd = 32'h0, sd = 32'hE6ECD8F8, rd;
  logic [1:0]  rr;
  logic [7:0]  mem [0:639];
  logic [7:0]  dq [$];
  int          fail_count = 0, tests_run = 0;
  wire         awr, wr, bv, ar, rv, irq, oe, so, itn, los, nr, pres, len, lp, scl, pl, sel;
  wire  [1:0]  br, rs;
  wire  [31:0] rdt;
  wire         sda = !(pl || (oe && !so));
  always #50 clock_i = !clock_i;
  pmmi_top uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .s_axi_awaddr_i(aa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(sb),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(aa), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .irq_o(irq), .module_select_n_i(sel), .scl_i(scl), .sda_i(sda), .sda_o(so),
    .sda_oe_o(oe), .laser_off_request_i(lo), .power_down_reset_i(pd), .interrupt_n_o(itn),
    .receive_signal_lost_oe_o(los), .fault_not_ready_oe_o(nr), .presence_indicator_o(pres),
    .laser_enable_o(len), .low_power_o(lp));
  pmmi_host_model host (.sda_i(sda), .scl_o(scl), .pl_o(pl), .sel_n_o(sel));
  function automatic logic [7:0] rnd8();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd[7:0];
  endfunction
  function automatic int phys(input logic [7:0] a);
    return a[7] ? (ts[1:0] + 1) * 128 + a[6:0] : a;
  endfunction
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One register access; bready or rready is held until the answer
  task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    aa <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    bre <= w;
    rre <= !w;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (ar) arv <= 1'b0;
    end while (!(w ? bv : rv) && n < 40);
    rd = rdt;
    rr = w ? br : rs;
    bre <= 1'b0;
    rre <= 1'b0;
    chk("response wait", n < 40, 1);
    if (n >= 40) results();
  endtask
  // Write bytes from dq, or read nb bytes after a repeated start
  task automatic frame(input logic [7:0] off, input bit rf, input int nb);
    host.st(1'b0);
    host.xb(8'hA0, 1'b1, q, k);
    chk("address ack", k, 0);
    host.xb(off, 1'b1, q, k);
    if (rf) host.st(1'b0);
    if (rf) host.xb(8'hA1, 1'b1, q, k);
    for (int i = 0; i < nb; i++)
    begin
      host.xb(rf ? 8'hFF : dq[i], rf ? i == nb - 1 : 1'b1, q, k);
      if (rf) chk("read byte", q, off == 8'h7F ? ts : mem[phys(off)]);
      if (!rf && off == 8'h7F) ts = dq[i];
      if (!rf) mem[phys(off)] = dq[i];
      off++;
    end
    host.sp();
  endtask
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk("presence", pres, 0);
    for (int v = 0; v < 8; v++)
    begin
      ax(1'b1, 8'h00, v);
      repeat (4) @(posedge clock_i);
      chk("pins", {itn, nr, los}, 3'h7 ^ v[2:0]);
    end
    sb <= 4'h0;
    ax(1'b1, 8'h00, 0);
    sb <= 4'hF;
    ax(1'b0, 8'h00, 0);
    chk("strobes", rd, 7);
    ax(1'b1, 8'h18, 1);
    chk("unmapped write", rr, 2);
    ax(1'b0, 8'h18, 0);
    chk("unmapped read", rr, 2);
    ce <= 1'b0;
    lo <= 1'b1;
    repeat (5) @(posedge clock_i);
    chk("frozen", len, 1);
    lo <= 1'b0;
    repeat (5) @(posedge clock_i);
    ce <= 1'b1;
    for (int b = 1; b >= 0; b--)
    begin
      lo <= b[0];
      repeat (5) @(posedge clock_i);
      chk("laser", len, !b[0]);
    end
    ax(1'b1, 8'h0C, 5);
    dq = {rnd8(), rnd8(), rnd8(), rnd8()};
    frame(8'h10, 1'b0, 4);
    repeat (6) @(posedge clock_i);
    chk("irq set", irq, 1);
    ax(1'b1, 8'h10, 32'h10);
    repeat (4) @(posedge clock_i);
    ax(1'b0, 8'h14, 0);
    chk("mem data", rd, mem[16]);
    ax(1'b0, 8'h04, 0);
    chk("status", rd, {16'h0, ts, 8'h10});
    ax(1'b1, 8'h08, 15);
    ax(1'b0, 8'h08, 0);
    chk("int clear", rd, 0);
    ax(1'b1, 8'h0C, 4);
    dq = {8'h01, rnd8(), rnd8()};
    frame(8'h7F, 1'b0, 3);
    dq = {8'h02, rnd8()};
    frame(8'h7F, 1'b0, 2);
    frame(8'h7F, 1'b1, 2);
    dq = {8'h01};
    frame(8'h7F, 1'b0, 1);
    chk("irq masked", irq, 0);
    @(posedge clock_i);
    pd <= 1'b1;
    repeat (5) @(posedge clock_i);
    chk("low power", lp, 1);
    frame(8'h80, 1'b1, 2);
    mem[8'h6E] = {6'h07, pd, lo};
    frame(8'h6E, 1'b1, 1);
    frame(8'h10, 1'b1, 4);
    @(posedge clock_i);
    pd <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk("reset event", irq, 1);
    ts = 8'h00;
    frame(8'h7F, 1'b1, 1);
    for (int j = 0; j < 2; j++)
    begin
      host.st(j[0]);
      host.xb(j[0] ? 8'hA0 : 8'hA2, 1'b1, q, k);
      chk("no ack", k, 1);
      host.sp();
    end
    results();
  end
endmodule
